// File: rtl/ccm_conv_seq.sv
// ccm_conv_seq: conversion channel sequencer, single channel or auto-scan.
// assumes conv_done_i is a one-cycle pulse from the converter, same clock.
`timescale 1ns/100ps
module ccm_conv_seq
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       run_i,
  input  wire logic       scan_i,
  input  wire logic [1:0] seq_i,
  input  wire logic [1:0] single_i,
  input  wire logic       conv_done_i,
  output logic [1:0]      chan_o,
  output ccm_pkg::ccm_state_e state_o
);

  ccm_pkg::ccm_state_e state_r;
  logic [1:0]          chan_r;

  // last channel of the chosen scan list; codes 00 and 11 both give 0,1
  function automatic logic [1:0] last_chan(input logic [1:0] seq);
    unique case (seq)
      ccm_pkg::SEQ_CH012:  last_chan = 2'h2;
      ccm_pkg::SEQ_CH0123: last_chan = 2'h3;
      default:             last_chan = 2'h1;
    endcase
  endfunction : last_chan

  // mode follows the scan bit; idle while held in reset or while run_i is low
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !run_i)
      state_r <= ccm_pkg::CCM_IDLE;
    else if (scan_i)
      state_r <= ccm_pkg::CCM_SCAN;
    else
      state_r <= ccm_pkg::CCM_SINGLE;
  end

  // channel walk: one conversion per channel, then wrap to channel 0
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !run_i)
      chan_r <= 2'h0;
    else if (!scan_i)
      chan_r <= single_i;
    else if (state_r != ccm_pkg::CCM_SCAN)
      chan_r <= 2'h0; // entering scan restarts at channel 0
    else if (conv_done_i)
    begin
      if (chan_r >= last_chan(seq_i))
        chan_r <= 2'h0;
      else
        chan_r <= chan_r + 2'h1;
    end
  end

  assign chan_o  = chan_r;
  assign state_o = state_r;

endmodule : ccm_conv_seq

// File: rtl/ccm_pkg.sv
// ccm_pkg: register map, field layout, reset values and encodings of the
// capacitive channel multiplexer control block.
// assumes registers are reached over a 32-bit AXI4-Lite slave.
package ccm_pkg;

  // printed offsets are not all multiples of four: they are word indexes
  localparam logic [7:0] IDX_MUX_CFG    = 8'h1b;
  localparam logic [7:0] IDX_RST_GAIN   = 8'h1c;
  localparam logic [7:0] IDX_DRV_CH0    = 8'h1e;
  localparam logic [7:0] IDX_DRV_CH1    = 8'h1f;
  localparam logic [7:0] IDX_CTRL       = 8'h1a;
  localparam logic [7:0] IDX_STATE      = 8'h40;

  // mux configuration fields
  localparam int MUX_SCAN_BIT = 15;
  localparam int MUX_SEQ_HI   = 14;
  localparam int MUX_SEQ_LO   = 13;
  localparam int MUX_RSV_HI   = 12;
  localparam int MUX_RSV_LO   = 3;
  localparam int MUX_DGL_HI   = 2;
  localparam int MUX_DGL_LO   = 0;
  localparam logic [15:0] MUX_RESET   = 16'h020f;

  // reset and gain fields
  localparam int RST_BIT      = 15;
  localparam int GAIN_HI      = 10;
  localparam int GAIN_LO      = 9;
  localparam logic [15:0] RST_RESET   = 16'h0000;

  // drive current fields
  localparam int DRV_HI       = 15;
  localparam int DRV_LO       = 11;
  localparam logic [15:0] DRV_RESET   = 16'h0000;

  // control register: single channel select in 15:14
  localparam int CTRL_CH_HI   = 15;
  localparam int CTRL_CH_LO   = 14;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;

  // scan sequence codes
  localparam logic [1:0] SEQ_CH01   = 2'h0;
  localparam logic [1:0] SEQ_CH012  = 2'h1;
  localparam logic [1:0] SEQ_CH0123 = 2'h2;

  // deglitch bandwidth codes
  localparam logic [2:0] DGL_1M    = 3'h1;
  localparam logic [2:0] DGL_3M3   = 3'h4;
  localparam logic [2:0] DGL_10M   = 3'h5;
  localparam logic [2:0] DGL_33M   = 3'h7;

  // gain shift amounts
  localparam logic [2:0] SHIFT_G1  = 3'h0;
  localparam logic [2:0] SHIFT_G4  = 3'h2;
  localparam logic [2:0] SHIFT_G8  = 3'h3;
  localparam logic [2:0] SHIFT_G16 = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CCM_IDLE = 3'b001,
    CCM_SINGLE = 3'b010,
    CCM_SCAN = 3'b100
  } ccm_state_e;

endpackage : ccm_pkg

// File: rtl/ccm_top.sv
// ccm_top: configuration registers and control of a capacitive converter
// channel multiplexer, with an AXI4-Lite register slave.
// assumes one 50 MHz clock; conv_done_i comes from converter logic on clk_i.
`timescale 1ns/100ps
module ccm_top
#(
  parameter int NUM_CHAN = 2
)
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // converter side
  input  wire logic        conv_done_i,
  input  wire logic [11:0] raw_result_i,
  output logic [1:0]       single_channel_select_o,
  output logic [4:0]       drive_code_o,
  output logic [2:0]       deglitch_o,
  output logic [15:0]      gained_result_o,
  output logic             soft_reset_o
);

  // only two- and four-channel variants exist; refuse others at elaboration
  if (NUM_CHAN != 2 && NUM_CHAN != 4)
  begin : g_bad_num_chan
    $error("ccm_top: NUM_CHAN must be 2 or 4");
  end

  logic [15:0] mux_r;
  logic [15:0] gain_r;
  logic [15:0] drv0_r;
  logic [15:0] drv1_r;
  logic [15:0] ctrl_r;
  logic        soft_rst_r;
  logic        dev_rst;
  logic [1:0]  chan;
  ccm_pkg::ccm_state_e state;

  // write channel holding regs: address and data taken in either order
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic        wr_hit;

  // registers and sequencer both clear on the soft reset pulse
  assign dev_rst = srst_i || soft_rst_r;

  // byte address is four times the printed index
  function automatic logic [7:0] to_idx(input logic [31:0] addr);
    to_idx = addr[9:2];
  endfunction : to_idx

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // mapped register indexes; anything else answers with an error response
  function automatic logic idx_ok(input logic [7:0] idx);
    idx_ok = (idx == ccm_pkg::IDX_MUX_CFG) || (idx == ccm_pkg::IDX_RST_GAIN) ||
             (idx == ccm_pkg::IDX_DRV_CH0) || (idx == ccm_pkg::IDX_DRV_CH1) ||
             (idx == ccm_pkg::IDX_CTRL)    || (idx == ccm_pkg::IDX_STATE);
  endfunction : idx_ok

  assign wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_hit = wr_go && idx_ok(aw_idx_r);

  // accept address and data independently, one write outstanding
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_idx_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ccm_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_idx_r  <= to_idx(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? ccm_pkg::RESP_OKAY : ccm_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // soft reset pulse: one cycle, the bit itself never stores
  always_ff @(posedge clk_i)
  begin
    if (dev_rst)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= wr_hit && aw_idx_r == ccm_pkg::IDX_RST_GAIN && wstrb_r[1] &&
                    wdata_r[ccm_pkg::RST_BIT];
  end

  // configuration registers; reserved bits kept as written, host keeps them
  always_ff @(posedge clk_i)
  begin
    if (dev_rst)
    begin
      mux_r  <= ccm_pkg::MUX_RESET;
      gain_r <= ccm_pkg::RST_RESET;
      drv0_r <= ccm_pkg::DRV_RESET;
      drv1_r <= ccm_pkg::DRV_RESET;
      ctrl_r <= ccm_pkg::CTRL_RESET;
    end
    else if (wr_hit)
    begin
      unique case (aw_idx_r)
        ccm_pkg::IDX_MUX_CFG:  mux_r  <= merge(mux_r, wdata_r, wstrb_r);
        ccm_pkg::IDX_RST_GAIN: gain_r <= merge(gain_r, wdata_r, wstrb_r) &
                                         ~(16'h0001 << ccm_pkg::RST_BIT);
        ccm_pkg::IDX_DRV_CH0:  drv0_r <= merge(drv0_r, wdata_r, wstrb_r);
        ccm_pkg::IDX_DRV_CH1:  drv1_r <= merge(drv1_r, wdata_r, wstrb_r);
        ccm_pkg::IDX_CTRL:     ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
        default:               ;
      endcase
    end
  end

  // read channel: one read at a time, answer two edges after arvalid
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ccm_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= idx_ok(to_idx(s_axi_araddr)) ? ccm_pkg::RESP_OKAY :
                        ccm_pkg::RESP_SLVERR;
        unique case (to_idx(s_axi_araddr))
          ccm_pkg::IDX_MUX_CFG:  s_axi_rdata <= {16'h0000, mux_r};
          ccm_pkg::IDX_RST_GAIN: s_axi_rdata <= {16'h0000, gain_r}; // bit 15 zero
          ccm_pkg::IDX_DRV_CH0:  s_axi_rdata <= {16'h0000, drv0_r};
          ccm_pkg::IDX_DRV_CH1:  s_axi_rdata <= {16'h0000, drv1_r};
          ccm_pkg::IDX_CTRL:     s_axi_rdata <= {16'h0000, ctrl_r};
          ccm_pkg::IDX_STATE:    s_axi_rdata <= {27'h0000000, state, chan};
          default:               s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // sequencer; codes beyond the channel count fold back to the 2-channel list
  logic [1:0] seq_eff;
  logic [1:0] single_eff;
  assign seq_eff    = (NUM_CHAN == 4) ? mux_r[ccm_pkg::MUX_SEQ_HI:ccm_pkg::MUX_SEQ_LO] :
                      ccm_pkg::SEQ_CH01;
  assign single_eff = (NUM_CHAN == 4) ? ctrl_r[ccm_pkg::CTRL_CH_HI:ccm_pkg::CTRL_CH_LO] :
                      {1'b0, ctrl_r[ccm_pkg::CTRL_CH_LO]};

  ccm_conv_seq u_seq
  (
    .clk_i       (clk_i),
    .srst_i      (dev_rst),
    .run_i       (1'b1),
    .scan_i      (mux_r[ccm_pkg::MUX_SCAN_BIT]),
    .seq_i       (seq_eff),
    .single_i    (single_eff),
    .conv_done_i (conv_done_i),
    .chan_o      (chan),
    .state_o     (state)
  );

  // gain code to shift amount
  function automatic logic [2:0] gain_shift(input logic [1:0] g);
    unique case (g)
      2'h0:    gain_shift = ccm_pkg::SHIFT_G1;
      2'h1:    gain_shift = ccm_pkg::SHIFT_G4;
      2'h2:    gain_shift = ccm_pkg::SHIFT_G8;
      default: gain_shift = ccm_pkg::SHIFT_G16;
    endcase
  endfunction : gain_shift

  // outputs registered; drive code follows the channel now converting
  always_ff @(posedge clk_i)
  begin
    if (dev_rst)
    begin
      single_channel_select_o   <= 2'h0;
      drive_code_o    <= 5'h00;
      deglitch_o      <= ccm_pkg::MUX_RESET[ccm_pkg::MUX_DGL_HI:ccm_pkg::MUX_DGL_LO];
      gained_result_o <= 16'h0000;
    end
    else
    begin
      single_channel_select_o <= chan;
      // channels 2 and 3 have no drive register here, they take code 0
      unique case (chan)
        2'h0:    drive_code_o <= drv0_r[ccm_pkg::DRV_HI:ccm_pkg::DRV_LO];
        2'h1:    drive_code_o <= drv1_r[ccm_pkg::DRV_HI:ccm_pkg::DRV_LO];
        default: drive_code_o <= 5'h00;
      endcase
      deglitch_o <= mux_r[ccm_pkg::MUX_DGL_HI:ccm_pkg::MUX_DGL_LO];
      if (conv_done_i)
        gained_result_o <= 16'({4'h0, raw_result_i} <<
                           gain_shift(gain_r[ccm_pkg::GAIN_HI:ccm_pkg::GAIN_LO]));
    end
  end

  // soft reset visible for one cycle to the analog side
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      soft_reset_o <= 1'b0;
    else
      soft_reset_o <= soft_rst_r;
  end

  // bit 15 of the reset register never holds a one
  property p_rst_reads_zero;
    @(posedge clk_i) disable iff (srst_i) !gain_r[ccm_pkg::RST_BIT];
  endproperty
  a_rst_reads_zero: assert property (p_rst_reads_zero)
    else $error("reset bit stored as one");

  property p_soft_rst_clears;
    @(posedge clk_i) disable iff (srst_i)
      soft_rst_r |=> (mux_r == ccm_pkg::MUX_RESET) && (drv0_r == ccm_pkg::DRV_RESET) &&
                     (gain_r == ccm_pkg::RST_RESET);
  endproperty
  a_soft_rst_clears: assert property (p_soft_rst_clears)
    else $error("soft reset did not restore registers");

  property p_soft_rst_from_write;
    @(posedge clk_i) disable iff (srst_i) $rose(soft_rst_r) |-> $past(wr_hit);
  endproperty
  a_soft_rst_from_write: assert property (p_soft_rst_from_write)
    else $error("soft reset without write");

  // soft reset clears outputs one edge after the pulse, so the delayed pulse
  // also guards: sampled inputs of that edge still hold pre-reset values
  property p_single_chan;
    @(posedge clk_i) disable iff (dev_rst || soft_reset_o)
      (!mux_r[ccm_pkg::MUX_SCAN_BIT] && state == ccm_pkg::CCM_SINGLE)[*2]
      |-> chan == $past(single_eff);
  endproperty
  a_single_chan: assert property (p_single_chan)
    else $error("single mode channel mismatch");

  property p_scan_state;
    @(posedge clk_i) disable iff (dev_rst || soft_reset_o)
      mux_r[ccm_pkg::MUX_SCAN_BIT] [*2] |-> state == ccm_pkg::CCM_SCAN;
  endproperty
  a_scan_state: assert property (p_scan_state)
    else $error("scan bit set but not scanning");

  property p_scan_wrap;
    @(posedge clk_i) disable iff (dev_rst || soft_reset_o)
      (state == ccm_pkg::CCM_SCAN && mux_r[ccm_pkg::MUX_SCAN_BIT] && conv_done_i &&
       chan == 2'h1 && seq_eff == ccm_pkg::SEQ_CH01) |=> chan == 2'h0;
  endproperty
  a_scan_wrap: assert property (p_scan_wrap)
    else $error("scan did not restart after channel 1");

  property p_drive_follow;
    @(posedge clk_i) disable iff (dev_rst || soft_reset_o)
      (chan == 2'h0) |=> drive_code_o == $past(drv0_r[ccm_pkg::DRV_HI:ccm_pkg::DRV_LO]);
  endproperty
  a_drive_follow: assert property (p_drive_follow)
    else $error("drive code not from channel 0 register");

  property p_gain16;
    @(posedge clk_i) disable iff (dev_rst || soft_reset_o)
      (conv_done_i && gain_r[ccm_pkg::GAIN_HI:ccm_pkg::GAIN_LO] == 2'h3)
      |=> gained_result_o == {$past(raw_result_i), 4'h0};
  endproperty
  a_gain16: assert property (p_gain16)
    else $error("gain 16 shift wrong");

  property p_deglitch;
    @(posedge clk_i) disable iff (dev_rst || soft_reset_o)
      ##1 deglitch_o == $past(mux_r[ccm_pkg::MUX_DGL_HI:ccm_pkg::MUX_DGL_LO]);
  endproperty
  a_deglitch: assert property (p_deglitch)
    else $error("deglitch output stale");

endmodule : ccm_top

// File: sim/ccm_conv_model.sv
// ccm_conv_model: behavioural converter that ends one conversion every
// gap_i+1 cycles and offers a fresh 12-bit raw result with each one.
// assumes the clock and synchronous reset of the block under test.
`timescale 1ns/100ps
module ccm_conv_model
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [3:0]  gap_i,
  output logic             conv_done_o,
  output logic [11:0]      raw_result_o
);
  logic [3:0] cnt_r;

  // pace conversions; a small gap is prompt, a large one is slow
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt_r       <= 4'h0;
      conv_done_o <= 1'b0;
    end
    else
    begin
      conv_done_o <= (cnt_r == gap_i);
      cnt_r       <= (cnt_r == gap_i) ? 4'h0 : cnt_r + 4'h1;
    end
  end

  // odd step walks all codes, so a slipped gain shift shows up
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      raw_result_o <= 12'h9a5;
    else if (conv_done_o)
      raw_result_o <= raw_result_o + 12'h3b7;
  end
endmodule : ccm_conv_model

// File: sim/tb.sv
// tb: self-checking bench for ccm_top over its register slave.
// assumes the converter model beside it and four channels fitted.
`timescale 1ns/100ps
module tb;
  logic        clk_i   = 1'b0;
  logic        srst_i  = 1'b1;
  logic [31:0] awaddr  = 32'h0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [31:0] araddr  = 32'h0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [3:0]  gap     = 4'h4;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, act;
  logic [31:0] rdata;
  logic        conv_done, srst_o;
  logic [11:0] raw;
  logic [4:0]  drv;
  logic [2:0]  dgl;
  logic [15:0] gres;
  logic [1:0]  chq[$];
  logic        rec = 1'b0;
  int          n_sr = 0;
  int          n_fail = 0;
  int          total_checks = 0;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  ccm_top #(.NUM_CHAN(4)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_done_i(conv_done), .raw_result_i(raw), .single_channel_select_o(act),
    .drive_code_o(drv), .deglitch_o(dgl), .gained_result_o(gres),
    .soft_reset_o(srst_o));

  ccm_conv_model u_conv (.clk_i(clk_i), .srst_i(srst_i), .gap_i(gap),
    .conv_done_o(conv_done), .raw_result_o(raw));

  // channel seen at each finished conversion, and soft reset pulses
  always @(posedge clk_i)
  begin
    if (rec && conv_done)
      chq.push_back(act);
    if (srst_o)
      n_sr++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one write; each channel held until its own ready edge
  task automatic axw(input logic [7:0] idx, input logic [15:0] d,
                     output logic [1:0] rsp);
    @(posedge clk_i);
    awaddr  <= {22'h0, idx, 2'h0};
    wdata   <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] idx, output logic [31:0] d,
                     output logic [1:0] rsp);
    @(posedge clk_i);
    araddr  <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [1:0] r;
    axw(idx, d, r);
    chk({30'h0, r}, {30'h0, ccm_pkg::RESP_OKAY});
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(idx, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, ccm_pkg::RESP_OKAY});
  endtask : rdc

  // wait for n finished conversions, then let outputs settle
  task automatic wconv(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      while (!conv_done) @(posedge clk_i);
    end
    repeat (2) @(posedge clk_i);
    #1;
  endtask : wconv

  task automatic conclude;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // hang guard, well above the several hundred cycles the tests need
  initial
  begin
    #(20 * 40000);
    n_fail++;
    conclude();
  end

  initial
  begin : main
    logic [2:0]  dg[4] = '{3'h1, 3'h4, 3'h5, 3'h7};
    logic [4:0]  dexp[4] = '{5'h15, 5'h0a, 5'h00, 5'h00};
    int          sh[4] = '{0, 2, 3, 4};
    logic [11:0] raw_s;
    logic [15:0] gx;
    logic [31:0] d;
    logic [1:0]  r;
    int          len;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    // reset values
    rdc(ccm_pkg::IDX_MUX_CFG, 32'h020f);
    rdc(ccm_pkg::IDX_RST_GAIN, 32'h0);
    rdc(ccm_pkg::IDX_DRV_CH0, 32'h0);
    rdc(ccm_pkg::IDX_DRV_CH1, 32'h0);
    chk({29'h0, dgl}, 32'h7);
    // every deglitch code; the last, 111, stays as lowest above the tank
    foreach (dg[i])
    begin
      wr(ccm_pkg::IDX_MUX_CFG, {3'h0, 10'h041, dg[i]});
      repeat (2) @(posedge clk_i);
      #1;
      chk({29'h0, dgl}, {29'h0, dg[i]});
    end
    // drive codes and single channel conversion, slow converter
    gap <= 4'h9;
    wr(ccm_pkg::IDX_DRV_CH0, 16'ha800);
    wr(ccm_pkg::IDX_DRV_CH1, 16'h5000);
    rdc(ccm_pkg::IDX_DRV_CH0, 32'ha800);
    rdc(ccm_pkg::IDX_DRV_CH1, 32'h5000);
    for (int c = 0; c < 4; c++)
    begin
      wr(ccm_pkg::IDX_CTRL, {c[1:0], 14'h0});
      wconv(3);
      chk({30'h0, act}, c);
      chk({27'h0, drv}, {27'h0, dexp[c]});
    end
    rdc(ccm_pkg::IDX_STATE, 32'h0b);
    // auto-scan over every sequence code, prompt converter
    gap <= 4'h4;
    for (int s = 0; s < 4; s++)
    begin
      len = (s == 1) ? 3 : (s == 2) ? 4 : 2;
      wr(ccm_pkg::IDX_MUX_CFG, {1'b1, s[1:0], 10'h041, 3'h7});
      chq.delete();
      rec = 1'b1;
      wconv(2 * len + 2);
      rec = 1'b0;
      // first two entries may straddle the mode change
      for (int i = 2; i < chq.size(); i++)
        chk({30'h0, chq[i]}, (chq[2] + i - 2) % len);
    end
    // gain shifts, checked on a result sampled at a finished conversion
    foreach (sh[g])
    begin
      wr(ccm_pkg::IDX_RST_GAIN, {5'h0, g[1:0], 9'h0});
      wconv(1);
      @(posedge clk_i);
      while (!conv_done) @(posedge clk_i);
      raw_s = raw;
      repeat (2) @(posedge clk_i);
      #1;
      gx = {4'h0, raw_s} << sh[g];
      chk({16'h0, gres}, {16'h0, gx});
    end
    // soft reset with gain bits set in the same word
    wr(ccm_pkg::IDX_RST_GAIN, 16'h8600);
    repeat (3) @(posedge clk_i);
    #1;
    chk(n_sr, 1);
    rdc(ccm_pkg::IDX_RST_GAIN, 32'h0);
    rdc(ccm_pkg::IDX_MUX_CFG, 32'h020f);
    rdc(ccm_pkg::IDX_DRV_CH0, 32'h0);
    rdc(ccm_pkg::IDX_CTRL, 32'h0);
    wconv(2);
    chk({30'h0, act}, 32'h0);
    chk({29'h0, dgl}, 32'h7);
    // unmapped index is refused both ways
    axr(8'h1d, d, r);
    chk({30'h0, r}, {30'h0, ccm_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    axw(8'h1d, 16'hffff, r);
    chk({30'h0, r}, {30'h0, ccm_pkg::RESP_SLVERR});
    conclude();
  end
endmodule : tb
